// ---- logic/smem_pkg.sv ----
// Package of constants shared by the serial memory slave files.
package smem_pkg;
	// ==========================================================
	// Geometry
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int DEPTH = 8192;
	localparam logic [12:0] ADDR_RESET = 13'h0000;
	localparam logic [12:0] ADDR_LAST = 13'h1fff;
	// ==========================================================
	// Slave address byte layout
	localparam int TYPE_MSB = 7;
	localparam int TYPE_LSB = 4;
	localparam int SEL_MSB = 3;
	localparam int SEL_LSB = 1;
	localparam int RW_BIT = 0;
	// Device type code; value is arbitrary and must be set per product.
	localparam logic [3:0] TYPE_CODE_DEFAULT = 4'h5;
	// ==========================================================
	// Bit counting
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// ==========================================================
	// Protocol states, one-hot
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_SADDR = 8'h02,
		ST_SACK = 8'h04,
		ST_ADDRH = 8'h08,
		ST_ADDRL = 8'h10,
		ST_WDATA = 8'h20,
		ST_RDATA = 8'h40,
		ST_RACK = 8'h80
	} smem_state_e;
endpackage

// ---- logic/smem_sync.sv ----
// Two-stage synchroniser for one asynchronous input.
`timescale 1ns/1ps
module smem_sync #(
	parameter logic INIT = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	logic meta;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= INIT;
			q <= INIT;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // smem_sync

// ---- logic/smem_slave.sv ----
// I2C slave front end and byte array of a serial memory.
// Summary of operation
// - SDA rising while SCL high is STOP.
// - STOP aborts any operation, back to idle.
// - SDA falling while SCL high is START.
// - START aborts, then expects slave address.
// - SDA steady while SCL high.
// - Drive after SCL fall, sample on rise.
// - Transmitter releases SDA in ack slot.
// - High SDA in ack slot ends operation.
// - Address bits 7-4 must equal type code.
// - Address bits 3-1 match select pins.
// - Address bit 0 one reads, zero writes.
// - Two address bytes load 13-bit latch.
// - Top three address bits are ignored.
// - Latch increments before each unprotected data ack slot.
// - Latch wraps from 1FFF to 0000.
// - Latch holds; reads start at latch.
// - Bursts have no length limit.
// - Read sends eight bits, then samples ack.
// - Write takes eight bits, acks; MSB first.
// - Write-protect high blocks every write.
// - Protected writes get no ack, no increment.
// - Byte committed only after eighth bit.
// - Repeated START read uses fresh address.
`timescale 1ns/1ps
module smem_slave #(
	parameter logic [3:0] TYPE_CODE = smem_pkg::TYPE_CODE_DEFAULT,
	parameter int DEPTH = smem_pkg::DEPTH
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic SCL,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_N,
	input wire logic [2:0] DEVICE_SELECT_PINS,
	input wire logic WRITE_PROTECT,
	output logic BUSY,
	output logic [12:0] ADDR_LATCH
);
	localparam int AW = smem_pkg::ADDR_W;

	// The array must span exactly the address space of the latch.
	if (DEPTH != (1 << AW)) begin : g_depth_check
		$error("DEPTH must equal two to the address width");
	end

	// ==========================================================
	// Input synchronisers and edge detection
	logic scl_s, sda_s, sel0_s, sel1_s, sel2_s, wp_s;
	logic scl_d, sda_d;
	smem_sync #(.INIT(1'b1)) u_scl (.clk(REF_CLK), .rst_n(RST_N),
		.d(SCL), .q(scl_s));
	smem_sync #(.INIT(1'b1)) u_sda (.clk(REF_CLK), .rst_n(RST_N),
		.d(SDA_I), .q(sda_s));
	smem_sync #(.INIT(1'b0)) u_sel0 (.clk(REF_CLK), .rst_n(RST_N),
		.d(DEVICE_SELECT_PINS[0]), .q(sel0_s));
	smem_sync #(.INIT(1'b0)) u_sel1 (.clk(REF_CLK), .rst_n(RST_N),
		.d(DEVICE_SELECT_PINS[1]), .q(sel1_s));
	smem_sync #(.INIT(1'b0)) u_sel2 (.clk(REF_CLK), .rst_n(RST_N),
		.d(DEVICE_SELECT_PINS[2]), .q(sel2_s));
	smem_sync #(.INIT(1'b1)) u_wp (.clk(REF_CLK), .rst_n(RST_N),
		.d(WRITE_PROTECT), .q(wp_s));

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	// Only data edges with SCL high in both samples count; this keeps a
	// data change at SCL fall from being misread as a condition.
	assign start_det = scl_s && scl_d && sda_d && !sda_s;
	assign stop_det = scl_s && scl_d && !sda_d && sda_s;

	// ==========================================================
	// Protocol state
	smem_pkg::smem_state_e state, ret_state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] tx;
	logic ack_phase;
	logic ack_ok;
	logic [12:0] addr;
	logic [4:0] addr_hi;
	logic [2:0] sel;
	logic [7:0] mem [DEPTH];
	logic [7:0] rd_byte;

	assign sel = {sel2_s, sel1_s, sel0_s};
	assign rd_byte = mem[addr];

	logic byte_done;
	logic [7:0] rx_byte;
	assign byte_done = scl_rise && (bit_cnt == smem_pkg::BIT_LAST);
	assign rx_byte = {shreg[6:0], sda_s};

	logic addr_match;
	assign addr_match =
		(rx_byte[smem_pkg::TYPE_MSB:smem_pkg::TYPE_LSB] == TYPE_CODE) &&
		(rx_byte[smem_pkg::SEL_MSB:smem_pkg::SEL_LSB] == sel);

	// Receive shift register and bit counter, sampled on SCL rise.
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			shreg <= smem_pkg::BYTE_RESET;
			bit_cnt <= 4'h0;
		end else if (start_det || stop_det) begin
			bit_cnt <= 4'h0;
		end else if (scl_rise && !ack_phase && state != smem_pkg::ST_IDLE) begin
			shreg <= rx_byte;
			bit_cnt <= (bit_cnt == smem_pkg::BIT_LAST) ? 4'h0 : bit_cnt + 4'h1;
		end
	end

	// Ack phase is the ninth clock: entered after the eighth rise, left on
	// the fall that ends the ninth clock.
	logic ack_rise_seen;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ack_phase <= 1'b0;
			ack_rise_seen <= 1'b0;
		end else if (start_det || stop_det) begin
			ack_phase <= 1'b0;
			ack_rise_seen <= 1'b0;
		end else if (byte_done && !ack_phase && state != smem_pkg::ST_IDLE) begin
			ack_phase <= 1'b1;
			ack_rise_seen <= 1'b0;
		end else if (ack_phase && scl_rise) begin
			ack_rise_seen <= 1'b1;
		end else if (ack_phase && ack_rise_seen && scl_fall) begin
			ack_phase <= 1'b0;
			ack_rise_seen <= 1'b0;
		end
	end

	// Main sequencer.
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= smem_pkg::ST_IDLE;
			ret_state <= smem_pkg::ST_IDLE;
			ack_ok <= 1'b0;
		end else if (start_det) begin
			state <= smem_pkg::ST_SADDR;
			ack_ok <= 1'b0;
		end else if (stop_det) begin
			state <= smem_pkg::ST_IDLE;
			ack_ok <= 1'b0;
		end else begin
			case (state)
			smem_pkg::ST_IDLE: begin
				ack_ok <= 1'b0;
			end
			smem_pkg::ST_SADDR: begin
				if (byte_done) begin
					ack_ok <= addr_match;
					state <= addr_match ? smem_pkg::ST_SACK : smem_pkg::ST_IDLE;
					ret_state <= rx_byte[smem_pkg::RW_BIT] ?
						smem_pkg::ST_RDATA : smem_pkg::ST_ADDRH;
				end
			end
			smem_pkg::ST_SACK, smem_pkg::ST_ADDRH, smem_pkg::ST_ADDRL,
			smem_pkg::ST_WDATA: begin
				if (ack_phase && ack_rise_seen && scl_fall) begin
					if (!ack_ok) begin
						state <= smem_pkg::ST_IDLE;
					end else if (state == smem_pkg::ST_SACK) begin
						state <= ret_state;
					end else if (state == smem_pkg::ST_ADDRH) begin
						state <= smem_pkg::ST_ADDRL;
					end else begin
						state <= smem_pkg::ST_WDATA;
					end
				end else if (byte_done && state != smem_pkg::ST_SACK) begin
					// Data bytes under protection are left unacknowledged.
					ack_ok <= !(state == smem_pkg::ST_WDATA && wp_s);
				end
			end
			smem_pkg::ST_RDATA: begin
				if (byte_done) begin
					state <= smem_pkg::ST_RACK;
				end
			end
			smem_pkg::ST_RACK: begin
				if (scl_rise) begin
					// A released SDA is a no-acknowledge and ends the read.
					state <= sda_s ? smem_pkg::ST_IDLE : smem_pkg::ST_RDATA;
				end
			end
			default: begin
				state <= smem_pkg::ST_IDLE;
			end
			endcase
		end
	end

	// Address latch: survives STOP and START, cleared only by reset.
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			addr <= smem_pkg::ADDR_RESET;
			addr_hi <= 5'h00;
		end else if (!start_det && !stop_det) begin
			if (byte_done && state == smem_pkg::ST_ADDRH) begin
				addr_hi <= rx_byte[4:0];
			end else if (byte_done && state == smem_pkg::ST_ADDRL) begin
				addr <= {addr_hi, rx_byte};
			end else if ((byte_done && state == smem_pkg::ST_WDATA && !wp_s) ||
				(byte_done && state == smem_pkg::ST_RDATA)) begin
				// Natural 13-bit overflow gives the wrap to zero.
				addr <= addr + 13'h0001;
			end
		end
	end

	// Array write happens only on the eighth rising edge of a data byte.
	always_ff @(posedge REF_CLK) begin
		if (byte_done && state == smem_pkg::ST_WDATA && !wp_s &&
			!start_det && !stop_det) begin
			mem[addr] <= rx_byte;
		end
	end

	// ==========================================================
	// SDA driver: changes on SCL falling edges, and is released at START and STOP.
	logic drive_low;
	logic load_first;
	// The MSB of a read byte goes out on the fall that closes the ack
	// slot before it, so it is settled well ahead of the next rise.
	assign load_first = ack_ok && (state == smem_pkg::ST_RDATA ||
		(state == smem_pkg::ST_SACK && ret_state == smem_pkg::ST_RDATA));
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			drive_low <= 1'b0;
			tx <= smem_pkg::BYTE_RESET;
		end else if (start_det || stop_det) begin
			drive_low <= 1'b0;
		end else if (scl_fall) begin
			if (ack_phase && !ack_rise_seen) begin
				// In a read the master owns the ack slot, so SDA is let go.
				drive_low <= ack_ok && state != smem_pkg::ST_IDLE &&
					state != smem_pkg::ST_RACK;
			end else if (ack_phase && load_first) begin
				drive_low <= !rd_byte[7];
				tx <= {rd_byte[6:0], 1'b1};
			end else if (state == smem_pkg::ST_RDATA && !ack_phase) begin
				drive_low <= !tx[7];
				tx <= {tx[6:0], 1'b1};
			end else begin
				drive_low <= 1'b0;
			end
		end
	end

	assign SDA_O = 1'b0;
	assign SDA_OE_N = !drive_low;
	assign BUSY = (state != smem_pkg::ST_IDLE);
	assign ADDR_LATCH = addr;

	// ==========================================================
	// Assertions
	sequence s_stop;
		scl_s && scl_d && !sda_d && sda_s;
	endsequence
	sequence s_start;
		scl_s && scl_d && sda_d && !sda_s;
	endsequence

	AST_STOP_IDLE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_stop |=> state == smem_pkg::ST_IDLE)
		else $error("stop did not return to idle");
	AST_STOP_DET: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_stop |=> SDA_OE_N && !BUSY)
		else $error("stop did not release the bus");
	AST_START_SADDR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_start |=> state == smem_pkg::ST_SADDR && bit_cnt == 4'h0)
		else $error("start did not arm address phase");
	AST_DRIVE_ON_FALL: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		$changed(SDA_OE_N) |-> $past(scl_fall) || $past(start_det)
		|| $past(stop_det))
		else $error("sda changed outside scl fall");
	AST_WRAP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		byte_done && state == smem_pkg::ST_RDATA && addr == smem_pkg::ADDR_LAST
		&& !start_det && !stop_det |=> addr == 13'h0000)
		else $error("latch did not wrap");
	AST_WP_NOINC: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		byte_done && state == smem_pkg::ST_WDATA && wp_s |=> $stable(addr))
		else $error("address advanced under protection");
	AST_MISMATCH: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		byte_done && state == smem_pkg::ST_SADDR && !addr_match && !start_det
		&& !stop_det |=> state == smem_pkg::ST_IDLE)
		else $error("foreign address accepted");
	AST_RNACK: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		state == smem_pkg::ST_RACK && scl_rise && sda_s && !start_det
		&& !stop_det |=> state == smem_pkg::ST_IDLE ##1 SDA_OE_N)
		else $error("read continued after no-acknowledge");
	AST_HOLD: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		state == smem_pkg::ST_IDLE && !start_det |=> $stable(addr))
		else $error("latch changed while idle");

	// Read launch and release: a late MSB or a held ack slot would make
	// the device fight the master on the wire.
	sequence s_read_load;
		scl_fall && ack_phase && ack_rise_seen && load_first;
	endsequence
	sequence s_read_ack_slot;
		scl_fall && ack_phase && !ack_rise_seen &&
		state == smem_pkg::ST_RACK;
	endsequence
	sequence s_protected_byte;
		byte_done && state == smem_pkg::ST_WDATA && wp_s;
	endsequence

	AST_MSB_ONE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_read_load ##0 rd_byte[7] |=> SDA_OE_N)
		else $error("read byte msb one not released");
	AST_MSB_ZERO: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_read_load ##0 !rd_byte[7] |=> !SDA_OE_N)
		else $error("read byte msb zero not driven");
	AST_RACK_FREE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_read_ack_slot |=> SDA_OE_N)
		else $error("sda held in master ack slot");
	AST_WP_NACK: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		s_protected_byte |=> !ack_ok)
		else $error("protected byte was acknowledged");
	// Incoming bits are counted only on SCL rises.
	AST_BIT_ON_RISE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		$changed(bit_cnt) |-> $past(scl_rise) || $past(start_det)
		|| $past(stop_det))
		else $error("bit counter moved outside scl rise");
	AST_ADDR_LOAD: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		byte_done && state == smem_pkg::ST_ADDRL |=>
		addr == {$past(addr_hi), $past(rx_byte)})
		else $error("address bytes not latched");
endmodule // smem_slave

// ---- testbench/smem_master.sv ----
// Bus master model that clocks the serial memory slave.
`timescale 1ns/1ps
module smem_master (
	input wire logic clk,
	input wire logic sda_in,
	output logic scl,
	output logic sda_out
);
	// ==========================================================
	// Bit level
	initial begin
		scl = 1'b1;
		sda_out = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// SDA moves one cycle after SCL falls, so the slave never sees a
	// data change inside a high phase.
	task automatic xfer_bit(input logic b, output logic s);
		wait_clk(1);
		sda_out <= b;
		wait_clk(4);
		scl <= 1'b1;
		wait_clk(3);
		s = sda_in;
		wait_clk(2);
		scl <= 1'b0;
	endtask
	task automatic start_cond();
		wait_clk(1);
		sda_out <= 1'b1;
		// Leaves room for a slave that is still letting go of its ack.
		wait_clk(4);
		scl <= 1'b1;
		wait_clk(3);
		sda_out <= 1'b0;
		wait_clk(3);
		scl <= 1'b0;
	endtask
	task automatic stop_cond();
		wait_clk(1);
		sda_out <= 1'b0;
		wait_clk(4);
		scl <= 1'b1;
		wait_clk(3);
		sda_out <= 1'b1;
		wait_clk(5);
	endtask
	// ==========================================================
	// Byte level
	task automatic put_byte(input logic [7:0] d, output logic ack_n);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(d[i], s);
		end
		xfer_bit(1'b1, ack_n);
	endtask
	task automatic get_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(1'b1, s);
			d[i] = s;
		end
		xfer_bit(last, s);
	endtask
endmodule // smem_master

// ---- testbench/smem_slave_tb.sv ----
// Self-checking bench for the serial memory slave.
`timescale 1ns/1ps
module smem_slave_tb;
	logic ref_clk;
	logic rst_n;
	logic scl;
	logic sda_m;
	logic sda_o;
	logic sda_oe_n;
	logic [2:0] sel;
	logic wp;
	logic busy;
	logic [12:0] addr_latch;
	wire sda_wire;
	int miscompares;
	int check_count;
	logic a;
	logic [7:0] d;

	// The wire is pulled up; each party can only pull it low.
	assign sda_wire = sda_m & (sda_oe_n | sda_o);

	smem_slave i_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .SCL(scl),
		.SDA_I(sda_wire), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n),
		.DEVICE_SELECT_PINS(sel), .WRITE_PROTECT(wp), .BUSY(busy),
		.ADDR_LATCH(addr_latch));
	smem_master i_master (.clk(ref_clk), .sda_in(sda_wire), .scl(scl),
		.sda_out(sda_m));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// ==========================================================
	// Access tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	function automatic logic [7:0] hdr(input logic [2:0] s, input logic rw);
		return {smem_pkg::TYPE_CODE_DEFAULT, s, rw};
	endfunction
	task automatic set_addr(input logic [15:0] ad);
		i_master.start_cond();
		i_master.put_byte(hdr(3'h3, 1'b0), a);
		check(a, 1'b0);
		i_master.put_byte(ad[15:8], a);
		check(a, 1'b0);
		i_master.put_byte(ad[7:0], a);
		check(a, 1'b0);
	endtask
	task automatic wr(input logic [7:0] dv, input logic exp_ack_n);
		i_master.put_byte(dv, a);
		check(a, exp_ack_n);
	endtask
	task automatic rd_start();
		i_master.start_cond();
		i_master.put_byte(hdr(3'h3, 1'b1), a);
		check(a, 1'b0);
	endtask
	task automatic rd(input logic last, input logic [7:0] exp);
		i_master.get_byte(last, d);
		check(d, exp);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 20 && busy !== 1'b0; i++) begin
			@(posedge ref_clk);
		end
		check(busy, 1'b0);
	endtask
	task automatic finish_op();
		i_master.stop_cond();
		wait_idle();
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		miscompares = 0;
		check_count = 0;
		rst_n = 1'b0;
		sel = 3'h3;
		wp = 1'b0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		check(addr_latch, 16'h0000);
		set_addr(16'hfffe);
		check(addr_latch, 16'h1ffe);
		wr(8'ha5, 1'b0);
		wr(8'h3c, 1'b0);
		check(addr_latch, 16'h0000);
		for (int i = 7; i >= 0; i--) begin
			i_master.xfer_bit(i != 0, a);
		end
		// The latch moves on before the ack slot of the byte.
		check(addr_latch, 16'h0001);
		i_master.xfer_bit(1'b1, a);
		check(a, 1'b0);
		wr(8'h5a, 1'b0);
		finish_op();
		$display("test wrap burst done");
		set_addr(16'h1ffe);
		rd_start();
		rd(1'b0, 8'ha5);
		rd(1'b0, 8'h3c);
		rd(1'b0, 8'hfe);
		rd(1'b1, 8'h5a);
		wait_idle();
		i_master.stop_cond();
		check(addr_latch, 16'h0002);
		$display("test random read done");
		i_master.start_cond();
		i_master.put_byte({~smem_pkg::TYPE_CODE_DEFAULT, 3'h3, 1'b0}, a);
		check(a, 1'b1);
		finish_op();
		for (int s = 0; s < 8; s++) begin
			i_master.start_cond();
			i_master.put_byte(hdr(s[2:0], 1'b0), a);
			check(a, s[2:0] != 3'h3);
			finish_op();
		end
		sel <= 3'h5;
		i_master.start_cond();
		i_master.put_byte(hdr(3'h3, 1'b0), a);
		check(a, 1'b1);
		finish_op();
		i_master.start_cond();
		i_master.put_byte(hdr(3'h5, 1'b0), a);
		check(a, 1'b0);
		finish_op();
		sel <= 3'h3;
		$display("test select done");
		wp <= 1'b1;
		set_addr(16'h0000);
		wr(8'h77, 1'b1);
		check(addr_latch, 16'h0000);
		finish_op();
		wp <= 1'b0;
		set_addr(16'h0000);
		for (int i = 0; i < 5; i++) begin
			i_master.xfer_bit(1'b0, a);
		end
		finish_op();
		set_addr(16'h0000);
		for (int i = 0; i < 3; i++) begin
			i_master.xfer_bit(1'b0, a);
		end
		rd_start();
		rd(1'b1, 8'hfe);
		finish_op();
		$display("test protect and abort done");
		final_report();
	end
	initial begin
		repeat (50000) @(posedge ref_clk);
		miscompares++;
		final_report();
	end
endmodule // smem_slave_tb
